/* File: hdl/e1_pins_cfg.svh */
// timing and reset constants for the e1 framer-side pin logic
`ifndef E1_PINS_CFG_SVH
`define E1_PINS_CFG_SVH

// reference clock period, ns
`define E1_REF_PERIOD_NS 40
// transmit clock held high this long before all-ones starts, ns
`define E1_ALL_ONES_TIME_NS 10000
// least time rounds up to whole reference cycles
`define E1_ALL_ONES_CYC ((`E1_ALL_ONES_TIME_NS + `E1_REF_PERIOD_NS - 1) / `E1_REF_PERIOD_NS)
// reference cycles without a master timing edge before it counts as absent
`define E1_MCLK_ABSENT_CYC 8'h20
// reset value of a rail pair
`define E1_RAIL_IDLE 2'h0

`endif

/* File: hdl/e1_pins_pkg.sv */
// types shared by the e1 framer-side pin logic
`default_nettype none

package e1_pins_pkg;

   // one bit time of the two line rails
   typedef struct packed {
      logic pos;
      logic neg;
   } rail_pair_s;

   // every asynchronous input, synchronised as one group
   typedef struct packed {
      logic hw_mode;
      logic slicer_bypass;
      logic single_rail;
      logic ami_sel;
      logic silence;
      logic line_clk;
      logic slice_pos;
      logic slice_neg;
      logic los;
      logic mclk;
      logic tx_clk;
      logic tx_pos;
      logic tx_neg;
   } pin_group_s;

   typedef enum logic {
      TX_NORMAL,
      TX_ALL_ONES
   } tx_state_e;

endpackage

`default_nettype wire

/* File: hdl/e1_pair_buffer.sv */
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module e1_pair_buffer #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_r;
   logic [PW-1:0] rd_r;
   logic [PW:0] count_r;
   logic push;
   logic pop;

   // full and empty straight from the occupancy count
   assign o_ready = (count_r != FULL);
   assign o_valid = (count_r != '0);
   assign o_data = mem_r[rd_r];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
      bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   // storage, no reset needed on data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= i_data;
      end
   end

   // pointers and count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_r <= '0;
         rd_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_r <= bump(wr_r);
         end
         if (pop) begin
            rd_r <= bump(rd_r);
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

/* File: hdl/e1_framer_pins.sv */
// framer-side digital pin logic of one e1 line channel
`include "e1_pins_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module e1_framer_pins
   import e1_pins_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   input wire logic I_HW_MODE,
   input wire logic I_SLICER_BYPASS,
   input wire logic I_SINGLE_RAIL,
   input wire logic I_AMI_SEL,
   input wire logic I_RECEIVE_SILENCE_CONTROL,
   input wire logic I_LINE_CLK,
   input wire logic I_SLICE_POS,
   input wire logic I_SLICE_NEG,
   input wire logic I_LOS_DETECT,
   input wire logic I_MCLK,
   input wire logic I_TRANSMIT_SAMPLING_CLOCK,
   input wire logic I_TRANSMIT_POSITIVE_RAIL,
   input wire logic I_TRANSMIT_NEGATIVE_RAIL,
   input wire logic I_SHAPER_READY,
   output logic O_RECOVERED_CLOCK_OUT,
   output logic O_RECEIVE_SIGNAL_LOSS_FLAG,
   output logic O_RECEIVE_POSITIVE_RAIL,
   output logic O_RECEIVE_NEGATIVE_RAIL,
   output logic O_TX_LINE_POS,
   output logic O_TX_LINE_NEG,
   output logic O_ALL_ONES_TRANSMIT,
   output logic O_TX_BUF_READY
);

   localparam logic [8:0] ALL_ONES_LIM = 9'(`E1_ALL_ONES_CYC);

   pin_group_s pins_w;
   pin_group_s meta_r;
   pin_group_s sync_r;
   logic line_clk_d_r;
   logic mclk_d_r;
   logic tx_clk_d_r;
   logic rx_edge;
   logic mclk_edge;
   logic tx_edge;
   logic [7:0] mclk_gap_r;
   logic mclk_absent_r;
   logic slice_mode;
   logic mute;
   logic bpv;
   logic last_pos_r;
   logic seen_mark_r;
   logic [8:0] tx_high_cnt_r;
   tx_state_e tx_state_r;
   tx_state_e tx_state_nxt;
   logic tx_mark_pos_r;
   logic ones_pos_r;
   rail_pair_s tx_word;
   rail_pair_s buf_word;
   logic buf_valid;
   logic buf_in_ready;
   logic buf_pop;

   function automatic logic rise(input logic prev, input logic cur);
      rise = cur && !prev;
   endfunction

   assign pins_w = '{hw_mode: I_HW_MODE, slicer_bypass: I_SLICER_BYPASS,
                     single_rail: I_SINGLE_RAIL, ami_sel: I_AMI_SEL,
                     silence: I_RECEIVE_SILENCE_CONTROL, line_clk: I_LINE_CLK,
                     slice_pos: I_SLICE_POS, slice_neg: I_SLICE_NEG,
                     los: I_LOS_DETECT, mclk: I_MCLK,
                     tx_clk: I_TRANSMIT_SAMPLING_CLOCK,
                     tx_pos: I_TRANSMIT_POSITIVE_RAIL,
                     tx_neg: I_TRANSMIT_NEGATIVE_RAIL};

   // two-stage synchroniser; only sync_r is read by logic
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= pins_w;
         sync_r <= meta_r;
      end
   end

   // delayed copies for edge finding on the sampled clocks
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         line_clk_d_r <= 1'b0;
         mclk_d_r <= 1'b0;
         tx_clk_d_r <= 1'b0;
      end else begin
         line_clk_d_r <= sync_r.line_clk;
         mclk_d_r <= sync_r.mclk;
         tx_clk_d_r <= sync_r.tx_clk;
      end
   end

   assign rx_edge = rise(line_clk_d_r, sync_r.line_clk);
   assign mclk_edge = rise(mclk_d_r, sync_r.mclk);
   assign tx_edge = rise(tx_clk_d_r, sync_r.tx_clk);

   // master timing watchdog; a stopped clock reads as absent
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         mclk_gap_r <= '0;
         mclk_absent_r <= 1'b0;
      end else begin
         if (mclk_edge) begin
            mclk_gap_r <= '0;
         end else if (mclk_gap_r != `E1_MCLK_ABSENT_CYC) begin
            mclk_gap_r <= mclk_gap_r + 1'b1;
         end
         mclk_absent_r <= (mclk_gap_r == `E1_MCLK_ABSENT_CYC);
      end
   end

   assign slice_mode = sync_r.slicer_bypass || (sync_r.hw_mode && mclk_absent_r);
   // silence only in hardware mode, only while loss persists
   assign mute = sync_r.hw_mode && sync_r.silence && sync_r.los;
   // same polarity as the previous mark is a bipolar violation
   assign bpv = seen_mark_r && ((sync_r.slice_pos && !sync_r.slice_neg && last_pos_r) ||
                                (sync_r.slice_neg && !sync_r.slice_pos && !last_pos_r));

   // recovered clock pin and loss flag
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         O_RECOVERED_CLOCK_OUT <= 1'b0;
         O_RECEIVE_SIGNAL_LOSS_FLAG <= 1'b0;
      end else begin
         if (slice_mode) begin
            O_RECOVERED_CLOCK_OUT <= sync_r.slice_pos | sync_r.slice_neg;
         end else begin
            O_RECOVERED_CLOCK_OUT <= sync_r.line_clk;
         end
         O_RECEIVE_SIGNAL_LOSS_FLAG <= sync_r.los;
      end
   end

   // polarity memory for violation checks
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         last_pos_r <= 1'b0;
         seen_mark_r <= 1'b0;
      end else if (rx_edge && (sync_r.slice_pos ^ sync_r.slice_neg)) begin
         last_pos_r <= sync_r.slice_pos;
         seen_mark_r <= 1'b1;
      end
   end

   // receive rails, updated once per line clock period
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         O_RECEIVE_POSITIVE_RAIL <= 1'b0;
         O_RECEIVE_NEGATIVE_RAIL <= 1'b0;
      end else if (mute) begin
         O_RECEIVE_POSITIVE_RAIL <= 1'b0;
         O_RECEIVE_NEGATIVE_RAIL <= 1'b0;
      end else if (rx_edge) begin
         if (sync_r.single_rail) begin
            O_RECEIVE_POSITIVE_RAIL <= sync_r.slice_pos | sync_r.slice_neg;
            // flag stands until the next edge: exactly one period
            O_RECEIVE_NEGATIVE_RAIL <= sync_r.ami_sel && bpv;
         end else begin
            O_RECEIVE_POSITIVE_RAIL <= sync_r.slice_pos;
            O_RECEIVE_NEGATIVE_RAIL <= sync_r.slice_neg;
         end
      end
   end

   // time how long the transmit clock has stayed high
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         tx_high_cnt_r <= '0;
      end else if (!sync_r.tx_clk) begin
         tx_high_cnt_r <= '0;
      end else if (tx_high_cnt_r <= ALL_ONES_LIM) begin
         tx_high_cnt_r <= tx_high_cnt_r + 1'b1;
      end
   end

   // all-ones entry and exit
   always_comb begin
      tx_state_nxt = tx_state_r;
      case (tx_state_r)
         TX_NORMAL: begin
            if (sync_r.hw_mode && sync_r.tx_clk && tx_high_cnt_r > ALL_ONES_LIM) begin
               tx_state_nxt = TX_ALL_ONES;
            end
         end
         TX_ALL_ONES: begin
            if (!sync_r.tx_clk || !sync_r.hw_mode) begin
               tx_state_nxt = TX_NORMAL;
            end
         end
         default: begin
            tx_state_nxt = TX_NORMAL;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         tx_state_r <= TX_NORMAL;
         O_ALL_ONES_TRANSMIT <= 1'b0;
      end else begin
         tx_state_r <= tx_state_nxt;
         O_ALL_ONES_TRANSMIT <= (tx_state_nxt == TX_ALL_ONES);
      end
   end

   // single rail ignores the negative input and encodes ami marks
   always_comb begin
      if (sync_r.single_rail) begin
         tx_word.pos = sync_r.tx_pos && tx_mark_pos_r;
         tx_word.neg = sync_r.tx_pos && !tx_mark_pos_r;
      end else begin
         tx_word.pos = sync_r.tx_pos;
         tx_word.neg = sync_r.tx_neg;
      end
   end

   // alternate mark polarity per accepted one; only a real push may flip it
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         tx_mark_pos_r <= 1'b1;
      end else if (tx_edge && buf_in_ready && (tx_state_r == TX_NORMAL) &&
                   sync_r.single_rail && sync_r.tx_pos) begin
         tx_mark_pos_r <= !tx_mark_pos_r;
      end
   end

   // drain at master timing rate; shaper stall backs up the buffer
   assign buf_pop = mclk_edge && I_SHAPER_READY && (tx_state_r == TX_NORMAL);

   e1_pair_buffer #(
      .WIDTH($bits(rail_pair_s)),
      .DEPTH(2)
   ) u_tx_buf (
      .clk(I_REF_CLK),
      .rst_n(I_RST_N),
      .i_valid(tx_edge && (tx_state_r == TX_NORMAL)),
      .o_ready(buf_in_ready),
      .i_data(tx_word),
      .o_valid(buf_valid),
      .i_ready(buf_pop),
      .o_data(buf_word)
   );

   // line-side marks, held for one master timing period, longer while I_SHAPER_READY is low outside all-ones
   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         {O_TX_LINE_POS, O_TX_LINE_NEG} <= `E1_RAIL_IDLE;
         ones_pos_r <= 1'b1;
         O_TX_BUF_READY <= 1'b0;
      end else begin
         O_TX_BUF_READY <= buf_in_ready;
         if (mclk_edge) begin
            if (tx_state_r == TX_ALL_ONES) begin
               O_TX_LINE_POS <= ones_pos_r;
               O_TX_LINE_NEG <= !ones_pos_r;
               ones_pos_r <= !ones_pos_r;
            end else if (buf_pop && buf_valid) begin
               {O_TX_LINE_POS, O_TX_LINE_NEG} <= buf_word;
            end else if (I_SHAPER_READY) begin
               {O_TX_LINE_POS, O_TX_LINE_NEG} <= `E1_RAIL_IDLE;
            end
         end
      end
   end

   AST_RCLK_SLICE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      slice_mode |=> O_RECOVERED_CLOCK_OUT == $past(sync_r.slice_pos | sync_r.slice_neg))
      else $error("clock pin not carrying sliced pulses");
   AST_LOS_RISE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(sync_r.los) |=> O_RECEIVE_SIGNAL_LOSS_FLAG)
      else $error("loss flag late");
   AST_DUAL_POS: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      rx_edge && !sync_r.single_rail && !mute |=> O_RECEIVE_POSITIVE_RAIL == $past(sync_r.slice_pos))
      else $error("positive rail wrong in dual rail");
   AST_SINGLE_NRZ: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      rx_edge && sync_r.single_rail && !mute
      |=> O_RECEIVE_POSITIVE_RAIL == $past(sync_r.slice_pos | sync_r.slice_neg))
      else $error("nrz data wrong in single rail");
   AST_DUAL_NEG: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      rx_edge && !sync_r.single_rail && !mute |=> O_RECEIVE_NEGATIVE_RAIL == $past(sync_r.slice_neg))
      else $error("negative rail wrong in dual rail");
   AST_CV_ON_EDGE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(O_RECEIVE_NEGATIVE_RAIL) |-> $past(rx_edge))
      else $error("negative pin changed between receive edges");
   AST_CV_AMI: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      rx_edge && sync_r.single_rail && sync_r.ami_sel && !mute && bpv |=> O_RECEIVE_NEGATIVE_RAIL)
      else $error("bipolar violation not flagged");
   AST_MUTE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      mute |=> !O_RECEIVE_POSITIVE_RAIL && !O_RECEIVE_NEGATIVE_RAIL)
      else $error("rails not silenced during loss");
   AST_NO_MUTE: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      rx_edge && sync_r.los && !sync_r.silence && !sync_r.single_rail
      |=> O_RECEIVE_POSITIVE_RAIL == $past(sync_r.slice_pos))
      else $error("rails suppressed with silence off");
   AST_ALL_ONES: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      sync_r.hw_mode && sync_r.tx_clk && tx_high_cnt_r > ALL_ONES_LIM |=> O_ALL_ONES_TRANSMIT)
      else $error("all-ones not entered");

endmodule

`default_nettype wire

/* File: testbench/e1_framer_model.sv */
// framer-side partner: transmit clock and transmit rails
`timescale 1ns/1ps
`default_nettype none

module e1_framer_model (
   input wire logic i_run,
   input wire logic i_idle_hi,
   input wire logic i_single_rail,
   input wire logic i_pos,
   input wire logic i_neg,
   output logic o_tx_clk,
   output logic o_tx_pos,
   output logic o_tx_neg
);
   // 320 ns clock inside frames, parked at a chosen level between them;
   // rails move on the falling edge so they are steady at the sampling edge
   initial begin
      o_tx_clk = 1'b0;
      o_tx_pos = 1'b0;
      o_tx_neg = 1'b0;
      // odd offset keeps every change clear of the reference clock edges
      #7;
      forever begin
         #20;
         if (i_run === 1'b1) begin
            o_tx_clk = 1'b0;
            o_tx_pos = i_pos;
            // unused rail toggles so a stale level can never pass for data
            o_tx_neg = (i_single_rail === 1'b1) ? ~o_tx_neg : i_neg;
            #160;
            o_tx_clk = 1'b1;
            #140;
         end else begin
            o_tx_clk = i_idle_hi;
         end
      end
   end
endmodule
`default_nettype wire

/* File: testbench/e1_framer_pins_bench.sv */
// self-checking bench for the e1 framer-side pin logic
`timescale 1ns/1ps
`default_nettype none

module e1_framer_pins_bench;
   logic clk, rst_n, hw, byp, sr, ami, sil, lclk, sp, sn, los, mclk, mclk_on, shp;
   logic tx_run, tx_hi, tx_p, tx_n, tx_clk, tx_pos, tx_neg;
   logic rclk_o, lossf, rxp, rxn, txp, txn, aones, bufr;
   int mismatches = 0;
   int checks_done = 0;

   e1_framer_pins e1_framer_pins_i (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_HW_MODE(hw), .I_SLICER_BYPASS(byp),
      .I_SINGLE_RAIL(sr), .I_AMI_SEL(ami), .I_RECEIVE_SILENCE_CONTROL(sil),
      .I_LINE_CLK(lclk), .I_SLICE_POS(sp), .I_SLICE_NEG(sn), .I_LOS_DETECT(los),
      .I_MCLK(mclk), .I_TRANSMIT_SAMPLING_CLOCK(tx_clk), .I_TRANSMIT_POSITIVE_RAIL(tx_pos),
      .I_TRANSMIT_NEGATIVE_RAIL(tx_neg), .I_SHAPER_READY(shp),
      .O_RECOVERED_CLOCK_OUT(rclk_o), .O_RECEIVE_SIGNAL_LOSS_FLAG(lossf),
      .O_RECEIVE_POSITIVE_RAIL(rxp), .O_RECEIVE_NEGATIVE_RAIL(rxn), .O_TX_LINE_POS(txp),
      .O_TX_LINE_NEG(txn), .O_ALL_ONES_TRANSMIT(aones), .O_TX_BUF_READY(bufr)
   );

   e1_framer_model e1_framer_model_i (
      .i_run(tx_run), .i_idle_hi(tx_hi), .i_single_rail(sr), .i_pos(tx_p), .i_neg(tx_n),
      .o_tx_clk(tx_clk), .o_tx_pos(tx_pos), .o_tx_neg(tx_neg)
   );

   // 25 MHz reference
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // master timing clock near 2.048 MHz, stoppable to fake its absence
   initial begin
      mclk = 1'b0;
      // odd offset keeps toggles off the reference clock edges
      #3;
      forever begin
         #244;
         mclk = (mclk_on === 1'b1) ? ~mclk : 1'b0;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // callers step 1 ns past the edge first, so got holds the settled value
   task automatic chk(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // one 520 ns line bit: data set with clock low, rails read at the bit's end
   task automatic send_bit(input logic p, input logic n);
      cyc(1);
      sp <= p;
      sn <= n;
      lclk <= 1'b0;
      cyc(6);
      lclk <= 1'b1;
      cyc(6);
      #1;
   endtask

   // counts cycles with each transmit mark, and with both at once
   task automatic watch(input int n, output int np, output int nn, output int nb);
      np = 0;
      nn = 0;
      nb = 0;
      repeat (n) begin
         cyc(1);
         #1;
         if (txp === 1'b1) np++;
         if (txn === 1'b1) nn++;
         if (txp === 1'b1 && txn === 1'b1) nb++;
      end
   endtask

   task automatic t_rx_dual;
      cyc(1);
      los <= 1'b1;
      ami <= 1'b1;
      cyc(5);
      #1;
      chk("loss_flag", 1'b1, lossf);
      cyc(1);
      los <= 1'b0;
      send_bit(1'b1, 1'b0);
      chk("loss_flag", 1'b0, lossf);
      send_bit(1'b1, 1'b0);
      chk("rx_pos", 1'b1, rxp);
      chk("rx_neg", 1'b0, rxn);
      send_bit(1'b0, 1'b1);
      chk("rx_pos", 1'b0, rxp);
      chk("rx_neg", 1'b1, rxn);
      $display("test rx_dual done");
   endtask

   task automatic t_rx_single;
      cyc(1);
      sr <= 1'b1;
      send_bit(1'b0, 1'b1);
      send_bit(1'b1, 1'b0);
      chk("rx_nrz", 1'b1, rxp);
      chk("rx_cv", 1'b0, rxn);
      send_bit(1'b1, 1'b0);
      chk("rx_cv", 1'b1, rxn);
      send_bit(1'b0, 1'b0);
      chk("rx_nrz", 1'b0, rxp);
      chk("rx_cv", 1'b0, rxn);
      send_bit(1'b0, 1'b1);
      chk("rx_nrz", 1'b1, rxp);
      chk("rx_cv", 1'b0, rxn);
      cyc(1);
      ami <= 1'b0;
      // same-polarity mark again; with ami off it must not flag
      send_bit(1'b0, 1'b1);
      chk("rx_cv_ami_off", 1'b0, rxn);
      cyc(1);
      sr <= 1'b0;
      $display("test rx_single done");
   endtask

   task automatic t_mute;
      cyc(1);
      hw <= 1'b1;
      sil <= 1'b1;
      los <= 1'b1;
      send_bit(1'b1, 1'b1);
      chk("rx_pos_muted", 1'b0, rxp);
      chk("rx_neg_muted", 1'b0, rxn);
      cyc(1);
      sil <= 1'b0;
      send_bit(1'b1, 1'b1);
      chk("rx_pos_open", 1'b1, rxp);
      chk("rx_neg_open", 1'b1, rxn);
      cyc(1);
      los <= 1'b0;
      hw <= 1'b0;
      $display("test mute done");
   endtask

   task automatic t_clock;
      cyc(1);
      byp <= 1'b1;
      lclk <= 1'b0;
      sp <= 1'b1;
      cyc(5);
      #1;
      chk("rclk_slice", 1'b1, rclk_o);
      cyc(1);
      sp <= 1'b0;
      sn <= 1'b1;
      cyc(5);
      #1;
      chk("rclk_slice", 1'b1, rclk_o);
      cyc(1);
      sn <= 1'b0;
      lclk <= 1'b1;
      cyc(5);
      #1;
      chk("rclk_slice", 1'b0, rclk_o);
      cyc(1);
      byp <= 1'b0;
      cyc(5);
      #1;
      chk("rclk_line", 1'b1, rclk_o);
      cyc(1);
      hw <= 1'b1;
      mclk_on <= 1'b0;
      lclk <= 1'b0;
      sp <= 1'b1;
      cyc(50);
      #1;
      chk("rclk_no_mclk", 1'b1, rclk_o);
      cyc(1);
      mclk_on <= 1'b1;
      hw <= 1'b0;
      sp <= 1'b0;
      $display("test clock done");
   endtask

   task automatic t_tx;
      int n;
      int np;
      int nn;
      int nb;
      cyc(1);
      shp <= 1'b0;
      tx_p <= 1'b1;
      tx_n <= 1'b0;
      tx_run <= 1'b1;
      n = 0;
      while (bufr !== 1'b0 && n < 80) begin
         cyc(1);
         n++;
      end
      #1;
      chk("buf_full", 1'b0, bufr);
      cyc(1);
      shp <= 1'b1;
      cyc(80);
      #1;
      chk("tx_pos", 1'b1, txp);
      chk("tx_neg", 1'b0, txn);
      cyc(1);
      tx_p <= 1'b0;
      tx_n <= 1'b1;
      cyc(80);
      #1;
      chk("tx_pos", 1'b0, txp);
      chk("tx_neg", 1'b1, txn);
      cyc(1);
      sr <= 1'b1;
      cyc(60);
      watch(80, np, nn, nb);
      chk("tx_quiet", 1'b1, (np + nn) == 0);
      cyc(1);
      tx_p <= 1'b1;
      watch(150, np, nn, nb);
      chk("tx_saw_pos", 1'b1, np > 0);
      chk("tx_saw_neg", 1'b1, nn > 0);
      chk("tx_no_both", 1'b1, nb == 0);
      // stop the framer and let the buffer run dry
      cyc(1);
      tx_run <= 1'b0;
      n = 0;
      while ((txp !== 1'b0 || txn !== 1'b0) && n < 100) begin
         cyc(1);
         n++;
      end
      #1;
      chk("tx_drained", 1'b0, txp | txn);
      chk("buf_ready", 1'b1, bufr);
      cyc(1);
      sr <= 1'b0;
      $display("test tx done");
   endtask

   task automatic t_all_ones;
      int np;
      int nn;
      int nb;
      cyc(1);
      hw <= 1'b1;
      tx_hi <= 1'b1;
      cyc(200);
      #1;
      chk("all_ones_early", 1'b0, aones);
      cyc(70);
      #1;
      chk("all_ones", 1'b1, aones);
      watch(100, np, nn, nb);
      chk("ones_pos", 1'b1, np > 0);
      chk("ones_neg", 1'b1, nn > 0);
      chk("ones_no_both", 1'b1, nb == 0);
      cyc(1);
      tx_hi <= 1'b0;
      cyc(10);
      #1;
      chk("all_ones_off", 1'b0, aones);
      cyc(1);
      hw <= 1'b0;
      $display("test all_ones done");
   endtask

   task automatic wrap_up;
      $display("counts: checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // cut a hang short; the whole run needs well under 150 us
   initial begin
      #400_000;
      mismatches++;
      $display("BAD watchdog expected finish seen timeout");
      wrap_up;
   end

   // reset, then each scenario in turn
   initial begin
      {rst_n, hw, byp, sr, ami, sil, lclk, sp, sn, los, shp} = 11'h000;
      {tx_run, tx_hi, tx_p, tx_n} = 4'h0;
      mclk_on = 1'b1;
      cyc(7);
      #1;
      chk("loss_flag_rst", 1'b0, lossf);
      chk("rx_pos_rst", 1'b0, rxp);
      cyc(1);
      rst_n <= 1'b1;
      cyc(3);
      #1;
      chk("buf_ready_rst", 1'b1, bufr);
      t_rx_dual;
      t_rx_single;
      t_mute;
      t_clock;
      t_tx;
      t_all_ones;
      wrap_up;
   end
endmodule
`default_nettype wire
